//--- pkg/rha_pkg.sv
// Constants, codes and map of the handshake remote-control block
// Function
// - Sequence begins on start pulse falling edge
// - Optional erase, then program, then verify
// - Busy asserts at start: busy transistor off
// - Pass output holds last action result
// - Pass valid only once busy is passive
// - Pass transistor on for success, else off
// - Button, handshake and command starts supported
// - One start input, busy and result outputs
// - Handshake start runs without host link
// - Missing target interface reports code 230
// - Supply above max 223, below min 224
package rha_pkg;
    // Clock rate and minimum start width
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned START_MIN_MS = 30;
    // Least time rounds up; product exceeds the signed 32-bit range
    localparam longint unsigned START_MIN_CYC_L =
        (longint'(START_MIN_MS) * longint'(CLK_HZ) + 64'd999) / 64'd1000;
    localparam int CNT_W = 22;
    localparam logic [CNT_W-1:0] START_MIN_CYC = CNT_W'(START_MIN_CYC_L);

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_RSLT = 8'h0C;
    localparam logic [7:0] A_VMAX = 8'h10;
    localparam logic [7:0] A_VMIN = 8'h14;
    localparam logic [7:0] A_VMEAS = 8'h18;

    // Control fields
    localparam int CTRL_CLR = 0;
    localparam int CTRL_GO = 1;
    // Status and mask fields
    localparam int STAT_W = 4;
    localparam int ST_DONE = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_REJ = 2;
    localparam int ST_SELF = 3;
    // Result fields
    localparam int RS_PASS = 8;
    localparam int RS_BUSY = 9;

    // Reset values
    localparam logic [15:0] VMAX_RST = 16'hFFFF;
    localparam logic [15:0] VMIN_RST = 16'h0000;

    // Error codes
    localparam logic [7:0] E_NONE = 8'h00;
    localparam logic [7:0] E_VERIFY = 8'hCB;
    localparam logic [7:0] E_CLEAR = 8'hCC;
    localparam logic [7:0] E_PROG = 8'hCE;
    localparam logic [7:0] E_VHIGH = 8'hDF;
    localparam logic [7:0] E_VLOW = 8'hE0;
    localparam logic [7:0] E_NOIF = 8'hE6;

    // Step codes to the flash engine
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_PROG = 2'h2;
    localparam logic [1:0] OP_VERIFY = 2'h3;

    // Sequencer states
    typedef enum logic [2:0] {
        S_POR, S_IDLE, S_CHECK, S_ERASE, S_PROG, S_VERIFY
    } rha_state_t;
endpackage

//--- rtl/rha_pulse_qual.sv
// Start-pulse qualifier: synchroniser, width timer, trailing-edge fire
`timescale 1ns/10ps
module rha_pulse_qual #(
    parameter logic [rha_pkg::CNT_W-1:0] MIN_CYC = rha_pkg::START_MIN_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic level_in,
    output logic fire,
    output logic reject
);
    import rha_pkg::*;

    // All state of the qualifier
    typedef struct packed {
        logic s1;
        logic s2;
        logic [CNT_W-1:0] cnt;
        logic fire;
        logic reject;
    } rha_qual_t;

    rha_qual_t q_r;
    rha_qual_t q_nxt;

    // Next state: time the high phase, judge at its fall
    always_comb begin
        q_nxt = q_r;
        q_nxt.s1 = level_in;
        q_nxt.s2 = q_r.s1;
        q_nxt.fire = 1'b0;
        q_nxt.reject = 1'b0;
        if (q_r.s2) begin
            // Saturate so very long pulses still count
            if (q_r.cnt != MIN_CYC) begin
                q_nxt.cnt = q_r.cnt + 1'b1;
            end
        end else begin
            // Falling edge: only s2 is looked at, never s1
            if (q_r.cnt == MIN_CYC) begin
                q_nxt.fire = 1'b1;
            end else if (q_r.cnt != '0) begin
                q_nxt.reject = 1'b1;
            end
            q_nxt.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign fire = q_r.fire;
    assign reject = q_r.reject;
endmodule // rha_pulse_qual

//--- rtl/rha_remote_ctrl.sv
// Handshake remote control and auto-sequence of the programmer
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module rha_remote_ctrl #(
    parameter logic [rha_pkg::CNT_W-1:0] START_MIN_CYC = rha_pkg::START_MIN_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Handshake start line and manual button
    input wire logic start_in,
    input wire logic button_in,
    // Self-test inputs
    input wire logic tgt_if_present,
    input wire logic [15:0] target_supply_voltage,
    // Flash engine handshake
    output logic op_req,
    output logic [1:0] op_code,
    input wire logic op_done,
    input wire logic op_ok,
    // Handshake outputs, high means transistor on
    output logic busy_xstr_on,
    output logic ok_xstr_on,
    // Front-panel LEDs and interrupt
    output logic led_busy,
    output logic led_pass,
    output logic led_fail,
    output logic irq
);
    import rha_pkg::*;

    // All state of the block
    typedef struct packed {
        rha_state_t st;
        logic clr_en;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        logic [15:0] vmax;
        logic [15:0] vmin;
        logic [7:0] err;
        logic busy;
        logic pass;
        logic op_req;
        logic [1:0] op_code;
        logic busy_xstr_on;
        logic ok_xstr_on;
        logic led_busy;
        logic led_pass;
        logic led_fail;
        logic irq;
        logic [31:0] rdata;
    } rha_state_s_t;

    rha_state_s_t r_r;
    rha_state_s_t r_nxt;

    // Qualified starts and rejects from both pins
    logic pin_fire;
    logic pin_rej;
    logic btn_fire;
    logic btn_rej;

    // Handshake start line qualifier
    rha_pulse_qual #(
        .MIN_CYC(START_MIN_CYC)
    ) u_pin_qual (
        .clk(clk),
        .resetn(resetn),
        .level_in(start_in),
        .fire(pin_fire),
        .reject(pin_rej)
    );

    // Button uses the same width rule, which also debounces it
    rha_pulse_qual #(
        .MIN_CYC(START_MIN_CYC)
    ) u_btn_qual (
        .clk(clk),
        .resetn(resetn),
        .level_in(button_in),
        .fire(btn_fire),
        .reject(btn_rej)
    );

    // Software start strobe from the control register
    logic sw_go;
    assign sw_go = reg_wr && (reg_addr == A_CTRL) && reg_wdata[CTRL_GO];

    // Any of the three ways starts the same sequence
    logic go;
    assign go = pin_fire | btn_fire | sw_go;

    // Supply comparison against the selected limits
    logic v_high;
    logic v_low;
    assign v_high = target_supply_voltage > r_r.vmax;
    assign v_low = target_supply_voltage < r_r.vmin;

    // Next-state logic: sequencer, registers, outputs
    always_comb begin
        logic [STAT_W-1:0] ev;
        logic fin;
        logic ok;
        logic [7:0] code;
        ev = '0;
        fin = 1'b0;
        ok = 1'b0;
        code = E_NONE;
        r_nxt = r_r;
        r_nxt.rdata = '0;

        // Short pulses on either input are flagged
        if (pin_rej || btn_rej) begin
            ev[ST_REJ] = 1'b1;
        end

        unique case (r_r.st)
            // Power-on self check of target interface
            S_POR: begin
                if (!tgt_if_present) begin
                    r_nxt.err = E_NOIF;
                    ev[ST_SELF] = 1'b1;
                end
                r_nxt.st = S_IDLE;
            end
            // Waiting; starts during a run are ignored
            S_IDLE: begin
                if (go) begin
                    r_nxt.busy = 1'b1;
                    r_nxt.st = S_CHECK;
                end
            end
            // Interface and supply checks before touching flash
            S_CHECK: begin
                if (!tgt_if_present) begin
                    fin = 1'b1;
                    code = E_NOIF;
                    ev[ST_SELF] = 1'b1;
                end else if (v_high) begin
                    fin = 1'b1;
                    code = E_VHIGH;
                    ev[ST_SELF] = 1'b1;
                end else if (v_low) begin
                    fin = 1'b1;
                    code = E_VLOW;
                    ev[ST_SELF] = 1'b1;
                end else if (r_r.clr_en) begin
                    r_nxt.st = S_ERASE;
                end else begin
                    r_nxt.st = S_PROG;
                end
            end
            // Erase step, only when clear-before-program is set
            S_ERASE: begin
                if (!r_r.op_req) begin
                    r_nxt.op_req = 1'b1;
                    r_nxt.op_code = OP_ERASE;
                end else if (op_done) begin
                    r_nxt.op_req = 1'b0;
                    r_nxt.op_code = OP_NONE;
                    if (op_ok) begin
                        r_nxt.st = S_PROG;
                    end else begin
                        fin = 1'b1;
                        code = E_CLEAR;
                    end
                end
            end
            // Programming step
            S_PROG: begin
                if (!r_r.op_req) begin
                    r_nxt.op_req = 1'b1;
                    r_nxt.op_code = OP_PROG;
                end else if (op_done) begin
                    r_nxt.op_req = 1'b0;
                    r_nxt.op_code = OP_NONE;
                    if (op_ok) begin
                        r_nxt.st = S_VERIFY;
                    end else begin
                        fin = 1'b1;
                        code = E_PROG;
                    end
                end
            end
            // Verification step ends the sequence
            S_VERIFY: begin
                if (!r_r.op_req) begin
                    r_nxt.op_req = 1'b1;
                    r_nxt.op_code = OP_VERIFY;
                end else if (op_done) begin
                    r_nxt.op_req = 1'b0;
                    r_nxt.op_code = OP_NONE;
                    fin = 1'b1;
                    ok = op_ok;
                    code = op_ok ? E_NONE : E_VERIFY;
                end
            end
            // Illegal codes recover to idle
            default: begin
                r_nxt.st = S_IDLE;
                r_nxt.op_req = 1'b0;
                r_nxt.busy = 1'b0;
            end
        endcase

        // Result and busy change on the same edge, so pass is settled
        // by the time the tester sees busy passive
        if (fin) begin
            r_nxt.st = S_IDLE;
            r_nxt.busy = 1'b0;
            r_nxt.pass = ok;
            r_nxt.err = code;
            ev[ST_DONE] = 1'b1;
            ev[ST_FAIL] = !ok;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                A_CTRL: r_nxt.clr_en = reg_wdata[CTRL_CLR];
                A_STAT: r_nxt.stat = r_r.stat & ~reg_wdata[STAT_W-1:0];
                A_MASK: r_nxt.mask = reg_wdata[STAT_W-1:0];
                A_VMAX: r_nxt.vmax = reg_wdata[15:0];
                A_VMIN: r_nxt.vmin = reg_wdata[15:0];
                default: ;
            endcase
        end
        // New events win over a same-cycle clear
        r_nxt.stat = r_nxt.stat | ev;

        // Read data valid in the next cycle only
        if (reg_rd) begin
            unique case (reg_addr)
                A_CTRL: r_nxt.rdata[CTRL_CLR] = r_r.clr_en;
                A_STAT: r_nxt.rdata[STAT_W-1:0] = r_r.stat;
                A_MASK: r_nxt.rdata[STAT_W-1:0] = r_r.mask;
                A_RSLT: r_nxt.rdata = {22'h0, r_r.busy, r_r.pass, r_r.err};
                A_VMAX: r_nxt.rdata[15:0] = r_r.vmax;
                A_VMIN: r_nxt.rdata[15:0] = r_r.vmin;
                A_VMEAS: r_nxt.rdata[15:0] = target_supply_voltage;
                default: r_nxt.rdata = '0;
            endcase
        end

        // Pin drives: busy active means transistor off
        r_nxt.busy_xstr_on = !r_nxt.busy;
        // Pass transistor on only for a good last action
        r_nxt.ok_xstr_on = r_nxt.pass && !r_nxt.busy;
        r_nxt.led_busy = r_nxt.busy;
        r_nxt.led_pass = r_nxt.pass && !r_nxt.busy;
        r_nxt.led_fail = !r_nxt.pass && !r_nxt.busy;
        r_nxt.irq = |(r_nxt.stat & r_nxt.mask);
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            r_r <= '0;
            r_r.st <= S_POR;
            r_r.vmax <= VMAX_RST;
            r_r.vmin <= VMIN_RST;
            r_r.busy_xstr_on <= 1'b1;
            r_r.led_fail <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = r_r.rdata;
    assign op_req = r_r.op_req;
    assign op_code = r_r.op_code;
    assign busy_xstr_on = r_r.busy_xstr_on;
    assign ok_xstr_on = r_r.ok_xstr_on;
    assign led_busy = r_r.led_busy;
    assign led_pass = r_r.led_pass;
    assign led_fail = r_r.led_fail;
    assign irq = r_r.irq;
endmodule // rha_remote_ctrl

//--- testbench/rha_sva.sv
// Port checker for the handshake remote-control block
`timescale 1ns/10ps
module rha_sva #(
    parameter logic [rha_pkg::CNT_W-1:0] START_MIN_CYC = rha_pkg::START_MIN_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start_in,
    input wire logic button_in,
    input wire logic op_req,
    input wire logic [1:0] op_code,
    input wire logic op_done,
    input wire logic op_ok,
    input wire logic busy_xstr_on,
    input wire logic ok_xstr_on,
    input wire logic led_busy
);
    import rha_pkg::*;
    int hc_r; // Consecutive high samples of the start line
    // Width timer mirrors the qualifier's count
    always_ff @(posedge clk) begin
        hc_r <= (!resetn || !start_in) ? 0 : hc_r + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Trailing edge of a wide or a narrow pulse while idle
    sequence s_long_end;
        $fell(start_in) && hc_r >= START_MIN_CYC && busy_xstr_on && !button_in;
    endsequence
    sequence s_short_end;
        $fell(start_in) && hc_r > 0 && hc_r < START_MIN_CYC && busy_xstr_on && !button_in;
    endsequence
    // Engine step finishing with a given outcome
    sequence s_step(logic [1:0] c, logic k);
        op_req && op_code == c && op_done && op_ok == k;
    endsequence
    a_busy_on_fall: assert property (s_long_end |-> ##[1:5] !busy_xstr_on)
        else $error("busy did not follow a valid start");
    a_no_rise_start: assert property ($rose(start_in) && busy_xstr_on && !button_in
        |-> busy_xstr_on[*4]) else $error("busy on leading edge");
    a_short_reject: assert property (s_short_end |-> busy_xstr_on[*6])
        else $error("short pulse started a run");
    a_ok_busy_off: assert property (!busy_xstr_on |-> !ok_xstr_on)
        else $error("pass shown while busy");
    a_ok_held: assert property (busy_xstr_on && $past(busy_xstr_on) |-> $stable(ok_xstr_on))
        else $error("pass changed while idle");
    a_erase_prog: assert property (s_step(OP_ERASE, 1'b1)
        |-> ##2 op_req && op_code == OP_PROG) else $error("program did not follow erase");
    a_prog_verify: assert property (s_step(OP_PROG, 1'b1)
        |-> ##2 op_req && op_code == OP_VERIFY) else $error("verify did not follow program");
    a_fail_end: assert property (op_req && op_done && !op_ok
        |=> busy_xstr_on && !ok_xstr_on && !op_req) else $error("bad failed end");
    a_pass_end: assert property (s_step(OP_VERIFY, 1'b1) |=> busy_xstr_on && ok_xstr_on)
        else $error("pass not shown after verify");
    a_led_busy: assert property (led_busy != busy_xstr_on)
        else $error("busy lamp disagrees with busy line");
    a_req_held: assert property (op_req && !op_done |=> op_req && $stable(op_code))
        else $error("step request dropped early");
endmodule // rha_sva
bind rha_remote_ctrl rha_sva #(.START_MIN_CYC(START_MIN_CYC)) chk (.clk(clk),
    .resetn(resetn), .start_in(start_in), .button_in(button_in), .op_req(op_req),
    .op_code(op_code), .op_done(op_done), .op_ok(op_ok), .busy_xstr_on(busy_xstr_on),
    .ok_xstr_on(ok_xstr_on), .led_busy(led_busy));

//--- testbench/rha_tester_model.sv
// Production tester model on the handshake lines
`timescale 1ns/10ps
module rha_tester_model (
    input wire logic clk,
    input wire logic busy_xstr_on,
    input wire logic ok_xstr_on,
    output logic start_in
);
    initial start_in = 1'b0; // Line idles low
    // Start line high for w edges, then low
    task automatic pulse(input int w);
        @(posedge clk);
        start_in <= 1'b1;
        repeat (w) @(posedge clk);
        start_in <= 1'b0;
    endtask
    // Bounded waits: busy active, then passive, then take the result
    task automatic await_result(output logic seen, output logic ok);
        seen = 1'b0;
        for (int n = 0; n < 12 && !seen; n++) begin
            @(posedge clk);
            #1 seen = !busy_xstr_on;
        end
        for (int n = 0; n < 400 && !busy_xstr_on; n++) begin
            @(posedge clk);
            #1;
        end
        ok = ok_xstr_on; // Only read once busy is passive
    endtask
endmodule // rha_tester_model

//--- testbench/tb.sv
// Self-checking bench of the handshake remote-control block
`timescale 1ns/10ps
module tb;
    import rha_pkg::*;
    localparam logic [CNT_W-1:0] MIN = 22'h14; // Short start width for sim
    localparam logic [31:0] FSEQ [4] = '{32'h0, 32'h1, 32'h6, 32'h1B};
    localparam logic [31:0] FCODE [4] = '{32'h0, 32'hCC, 32'hCE, 32'hCB};
    localparam logic [15:0] VS [4] = '{16'h200, 16'h10, 16'h100, 16'h80};
    localparam logic [31:0] VR [4] = '{32'hDF, 32'hE0, 32'h100, 32'h100};
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, ops = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic start_in, button_in = 1'b0, tgt_if_present = 1'b0, seen, ok;
    logic [15:0] tsv = 16'h40;
    logic op_req, op_done = 1'b0, op_ok = 1'b0;
    logic [1:0] op_code, bad_op = 2'h0;
    logic busy_xstr_on, ok_xstr_on, led_busy, led_pass, led_fail, irq;
    int ecnt = 0, fail_count = 0, compares = 0;
    initial forever #4 clk = ~clk;
    rha_remote_ctrl #(.START_MIN_CYC(MIN)) dut (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .start_in(start_in), .button_in(button_in),
        .tgt_if_present(tgt_if_present), .target_supply_voltage(tsv), .op_req(op_req),
        .op_code(op_code), .op_done(op_done), .op_ok(op_ok), .busy_xstr_on(busy_xstr_on),
        .ok_xstr_on(ok_xstr_on), .led_busy(led_busy), .led_pass(led_pass),
        .led_fail(led_fail), .irq(irq));
    rha_tester_model tst (.clk(clk), .busy_xstr_on(busy_xstr_on),
        .ok_xstr_on(ok_xstr_on), .start_in(start_in));
    // Flash engine stand-in: each step done after three cycles, one step may fail
    always @(posedge clk) begin
        op_done <= 1'b0;
        if (op_req && !op_done) begin
            ecnt <= ecnt + 1;
            if (ecnt == 2) begin
                op_done <= 1'b1;
                op_ok <= (op_code != bad_op);
                ops <= {ops[5:0], op_code};
                ecnt <= 0;
            end
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask
    // Interrupt is registered, so let it settle first
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk);
        #1 check("irq", 32'(exp), 32'(irq));
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #400000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(A_RSLT, 32'hE6, "no interface code");
        rd(A_STAT, 32'h8, "self-test status");
        rd(A_VMAX, 32'hFFFF, "max reset");
        rd(A_VMIN, 32'h0, "min reset");
        rd(8'h40, 32'h0, "unmapped read");
        tgt_if_present <= 1'b1;
        wr(A_STAT, 32'hF);
        wr(A_MASK, 32'h1);
        wr(A_CTRL, 32'h1);
        irq_is(1'b0);
        // One cycle short of the width: refused, flagged only
        tst.pulse(int'(MIN) - 1);
        tst.await_result(seen, ok);
        check("short start busy", 32'h0, 32'(seen));
        rd(A_STAT, 32'h4, "reject status");
        irq_is(1'b0);
        wr(A_MASK, 32'h5);
        irq_is(1'b1);
        wr(A_STAT, 32'h4);
        irq_is(1'b0);
        // Exactly the width: full erase, program, verify, no host traffic
        ops = 8'h00;
        tst.pulse(int'(MIN));
        tst.await_result(seen, ok);
        check("start busy", 32'h1, 32'(seen));
        check("start pass", 32'h1, 32'(ok));
        check("pass lamp", 32'h1, 32'(led_pass));
        check("fail lamp", 32'h0, 32'(led_fail));
        check("auto steps", 32'h1B, 32'(ops));
        rd(A_RSLT, 32'h100, "pass result");
        irq_is(1'b1);
        wr(A_STAT, 32'h1);
        // Button start without erase
        wr(A_CTRL, 32'h0);
        ops = 8'h00;
        @(posedge clk);
        button_in <= 1'b1;
        repeat (int'(MIN)) @(posedge clk);
        button_in <= 1'b0;
        tst.await_result(seen, ok);
        check("button pass", 32'h1, 32'(ok));
        check("button steps", 32'h0B, 32'(ops));
        // Software starts, each step failing in turn
        for (int i = 1; i < 4; i++) begin
            bad_op = 2'(i);
            ops = 8'h00;
            wr(A_CTRL, 32'h3);
            tst.await_result(seen, ok);
            check("failed pass", 32'h0, 32'(ok));
            check("failed lamp", 32'h1, 32'(led_fail));
            check("failed steps", FSEQ[i], 32'(ops));
            rd(A_RSLT, FCODE[i], "failed code");
        end
        bad_op = 2'h0;
        // Supply above, below and on both limits
        wr(A_VMAX, 32'h100);
        wr(A_VMIN, 32'h80);
        for (int j = 0; j < 4; j++) begin
            tsv <= VS[j];
            wr(A_CTRL, 32'h3);
            tst.await_result(seen, ok);
            rd(A_RSLT, VR[j], "supply result");
            rd(A_VMEAS, 32'(VS[j]), "supply reading");
        end
        // Interface lost later: the pre-flash check refuses the run
        tgt_if_present <= 1'b0;
        wr(A_CTRL, 32'h2);
        tst.await_result(seen, ok);
        rd(A_RSLT, 32'hE6, "lost interface code");
        check("lost interface pass", 32'h0, 32'(ok));
        report_and_stop;
    end
endmodule // tb
